// *** dv/rxaf_phy_model.sv ***
module rxaf_phy_model (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------
  // Receive byte stream
  // ----------
  logic [7:0] fb [0:63];

  // Idle line until the first frame
  initial
  begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
  end

  // One byte per edge, gap idles between bytes for a slow line.
  // Idle data is inverted so a stale byte never looks fresh.
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == n - 1);
      rx_data <= fb[i];
      repeat ((i == n - 1) ? gap + 1 : gap)
      begin
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~fb[i];
      end
    end
  endtask
endmodule

// *** dv/test_rx_address_filter_and_wake_pattern.sv ***
module test_rx_address_filter_and_wake_pattern
  import rxaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [47:0] STA = 48'h0A0B_0C0D_0E02;
  localparam logic [47:0] OTH = 48'h0A0B_0C0D_0E04;
  localparam logic [47:0] MCA = 48'h6655_4433_2211;
  localparam logic [47:0] MCB = 48'h1234_5678_9A03;
  localparam logic [47:0] BCA = 48'hFFFF_FFFF_FFFF;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pwr_state_d1 = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_sof, rx_eof;
  logic fwd_valid, fwd_sof, fwd_eof, fwd_accept, irq_out, power_event_out;
  logic [7:0] rx_data, fwd_data;
  logic [31:0] hh = 32'h0;
  logic [31:0] hl = 32'h0;
  logic acc_q = 1'b0;
  int fails = 0;
  int checks = 0;
  int fwds = 0;
  int eofs = 0;

  rxaf_top u_rxaf_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data), .pwr_state_d1(pwr_state_d1), .fwd_valid(fwd_valid), .fwd_sof(fwd_sof),
    .fwd_eof(fwd_eof), .fwd_data(fwd_data), .fwd_accept(fwd_accept), .irq_out(irq_out),
    .power_event_out(power_event_out));
  rxaf_phy_model u_rxaf_phy_model (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_data(rx_data));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Count forwarded bytes and frame ends
  always @(posedge clk_sys)
  begin
    if (fwd_sof)
      chk(32'(fwds), 32'h0);
    if (fwd_valid)
    begin
      chk({24'h0, fwd_data}, {24'h0, u_rxaf_phy_model.fb[fwds]});
      fwds <= fwds + 1;
    end
    if (fwd_eof)
    begin
      eofs <= eofs + 1;
      acc_q <= fwd_accept;
    end
  end

  // ----------
  // Shared tasks
  // ----------
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  // Hash index from the address bits in wire order
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] r;
    r = 32'hFFFF_FFFF;
    for (int i = 0; i < 48; i++)
      r = (r[0] ^ da[i]) ? ((r >> 1) ^ 32'hEDB8_8320) : (r >> 1);
    return r[31:26];
  endfunction

  function automatic logic hit(input logic [47:0] da);
    logic [5:0] ix;
    ix = hidx(da);
    return ix[5] ? hh[ix[4:0]] : hl[ix[4:0]];
  endfunction

  task automatic hset(input logic [47:0] da);
    logic [5:0] ix;
    ix = hidx(da);
    if (ix[5])
      hh[ix[4:0]] = 1'b1;
    else
      hl[ix[4:0]] = 1'b1;
    wr(OFS_HASH_HI, hh);
    wr(OFS_HASH_LO, hl);
  endtask

  // Payload byte k holds k, so the pattern CRC is known up front
  function automatic logic [15:0] c16(input logic [7:0] off, input logic [30:0] m);
    logic [15:0] r;
    logic [7:0] b;
    r = 16'hFFFF;
    for (int j = 0; j < 31; j++)
    begin
      b = 8'(int'(off) + j);
      for (int i = 0; i < 8; i++)
        if (m[j])
          r = (r[0] ^ b[i]) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // Send one frame and judge frame ends, accept flag and forwarded bytes
  task automatic xfr(input logic [47:0] da, input int n, input int gap, input logic [7:0] cor,
                     input int ee, input logic ea, input int ef);
    for (int k = 0; k < 6; k++)
      u_rxaf_phy_model.fb[k] = da[8*k +: 8];
    for (int k = 6; k < 64; k++)
      u_rxaf_phy_model.fb[k] = 8'(k);
    u_rxaf_phy_model.fb[16] ^= cor;
    fwds = 0;
    eofs = 0;
    u_rxaf_phy_model.send(n, gap);
    repeat (3) @(posedge clk_sys);
    chk(32'(eofs), 32'(ee));
    if (ee != 0)
      chk({31'h0, acc_q}, {31'h0, ea});
    chk(32'(fwds), 32'(ef));
  endtask

  task automatic xfa(input logic [47:0] da, input logic ea);
    xfr(da, 8, 0, 8'h00, 1, ea, ea ? 8 : 6);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(OFS_STATION_HI, 32'h0000_FFFF);
    rd(OFS_MAC_CONTROL, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(OFS_STATION_HI, {16'h0, STA[47:32]});
    wr(OFS_STATION_LO, STA[31:0]);
    rd(OFS_STATION_LO, STA[31:0]);
    // Lane zero only; the upper three bytes must keep the station value
    pstrb <= 4'h1;
    wr(OFS_STATION_LO, 32'h0000_0055);
    pstrb <= 4'hF;
    rd(OFS_STATION_LO, {STA[31:8], 8'h55});
    wr(OFS_STATION_LO, STA[31:0]);
  endtask

  task automatic t_perfect;
    wr(OFS_MAC_CONTROL, 32'h0);
    xfa(STA, 1'b1);
    xfa(OTH, 1'b0);
    xfa(STA ^ 48'h8000_0000_0000, 1'b0);
    xfa(MCA, 1'b0);
    xfr(STA, 4, 2, 8'h00, 1, 1'b0, 4);
  endtask

  task automatic t_hash;
    hset(MCA);
    wr(OFS_MAC_CONTROL, 32'h10);
    xfa(MCA, 1'b1);
    xfa(MCB, hit(MCB));
    xfa(OTH, 1'b0);
    xfa(STA, 1'b1);
    hset(OTH);
    wr(OFS_MAC_CONTROL, 32'h18);
    xfa(OTH, 1'b1);
    xfa(STA, hit(STA));
  endtask

  task automatic t_modes;
    wr(OFS_MAC_CONTROL, 32'h04);
    xfa(STA, 1'b0);
    xfa(OTH, 1'b1);
    wr(OFS_MAC_CONTROL, 32'h3B);
    xfa(BCA, 1'b1);
    xfa(OTH, 1'b1);
    wr(OFS_MAC_CONTROL, 32'h02);
    xfa(MCB, 1'b1);
    xfa(OTH, 1'b0);
    xfa(STA, 1'b1);
    wr(OFS_MAC_CONTROL, 32'h1A);
    xfa(OTH, 1'b1);
    xfa(STA, hit(STA));
  endtask

  task automatic t_wake;
    logic [15:0] c;
    c = c16(8'h0E, 31'h5);
    wr(OFS_MAC_CONTROL, 32'h22);
    // Whole table in eight writes before detection is switched on
    wr(OFS_WAKE_TABLE, 32'h0000_0005);
    wr(OFS_WAKE_TABLE, 32'h0000_0005);
    wr(OFS_WAKE_TABLE, 32'h0);
    wr(OFS_WAKE_TABLE, 32'h0);
    wr(OFS_WAKE_TABLE, 32'h0000_0901);
    wr(OFS_WAKE_TABLE, 32'h0000_0E0E);
    wr(OFS_WAKE_TABLE, {c, c});
    wr(OFS_WAKE_TABLE, 32'h0);
    wr(OFS_WAKE_CS, 32'h0000_0006);
    xfr(STA, 20, 0, 8'h40, 0, 1'b0, 0);
    rd(OFS_WAKE_CS, 32'h0000_0006);
    xfr(STA, 20, 1, 8'h00, 0, 1'b0, 0);
    rd(OFS_WAKE_CS, 32'h0000_0007);
    chk({30'h0, irq_out, power_event_out}, 32'h2);
    wr(OFS_WAKE_CS, 32'h0000_0009);
    rd(OFS_WAKE_CS, 32'h0000_0008);
    chk({30'h0, irq_out, power_event_out}, 32'h0);
    xfa(STA, 1'b1);
    wr(OFS_WAKE_CS, 32'h0000_000A);
    xfr(BCA, 20, 0, 8'h00, 0, 1'b0, 0);
    rd(OFS_WAKE_CS, 32'h0000_000B);
    chk({30'h0, irq_out, power_event_out}, 32'h1);
    wr(OFS_WAKE_CS, 32'h0000_0001);
  endtask

  task automatic t_d1;
    pwr_state_d1 <= 1'b1;
    xfr(STA, 20, 0, 8'h00, 0, 1'b0, 0);
    rd(OFS_WAKE_CS, 32'h0000_0001);
    // Enable written low while D1 still holds detection on
    wr(OFS_WAKE_CS, 32'h0000_0001);
    rd(OFS_RX_STATUS, 32'h0000_0003);
    pwr_state_d1 <= 1'b0;
    xfa(STA, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_perfect();
    t_hash();
    t_modes();
    t_wake();
    t_d1();
    end_sim();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule

// *** verilog/rxaf_pkg.sv ***
package rxaf_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the APB
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAC_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATION_HI = 8'h04;
  localparam logic [7:0] OFS_STATION_LO = 8'h08;
  localparam logic [7:0] OFS_HASH_HI = 8'h0C;
  localparam logic [7:0] OFS_HASH_LO = 8'h10;
  localparam logic [7:0] OFS_WAKE_TABLE = 8'h14;
  localparam logic [7:0] OFS_WAKE_CS = 8'h18;
  localparam logic [7:0] OFS_RX_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ACCEPT_ALL = 0;
  localparam int CTL_MCAST_PASS = 1;
  localparam int CTL_INVERSE = 2;
  localparam int CTL_HASH_ONLY = 3;
  localparam int CTL_HASH_PERF = 4;
  localparam int CTL_BROADCAST_BLOCK_BLOCK = 5;
  localparam int CTL_WIDTH = 6;
  localparam int WCS_SEEN = 0;
  localparam int WCS_ENABLE = 1;
  localparam int WCS_IRQ_SEL = 2;
  localparam int WCS_PME_SEL = 3;
  localparam int WCS_PTR_LSB = 8;
  localparam int STS_WAKE_ACTIVE = 0;
  localparam int STS_LAST_ACCEPT = 1;
  localparam int CMD_ENABLE = 0;
  localparam int CMD_MCAST = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_STATION_HI = 16'hFFFF;
  localparam logic [31:0] RST_STATION_LO = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Sizes and CRC constants
  // ----------------------------------------------------------------
  localparam int FILT_COUNT = 4;
  localparam int TABLE_WORDS = 8;
  localparam int MASK_BITS = 31;
  localparam int DA_LAST = 5;
  localparam int POS_W = 11;
  localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;

  // Reflected CRC-32, one byte, LSB first as sent on the wire
  function automatic logic [31:0] rxaf_crc32(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC32_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Reflected CRC-16, one byte, LSB first
  function automatic logic [15:0] rxaf_crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// *** verilog/rxaf_top.sv ***
// Functional notes
// - First received destination bit marks multicast versus physical address.
// - Frames failing the active filter are not passed toward the host; here up to six leading bytes and fwd_eof still go out, with fwd_accept low.
// - All selection bits clear: perfect match for physical and multicast.
// - Hash-perfect only: physical perfect-matched, multicast hash-filtered.
// - Hash-only plus hash-perfect: hash filter for all destinations.
// - Inverse: accept frames not matching station address, reject matches.
// - Accept-all without inverse: every frame accepted, broadcasts too.
// - Multicast pass-all accepts multicast; physical perfect or hashed.
// - Perfect match compares all 48 bits against high and low station.
// - Hash index is top six bits of destination address CRC.
// - Index MSB picks high or low hash word, five bits pick bit.
// - Wake enable in D0 stops normal reception, checks wake patterns.
// - Wake frame raises host interrupt, power event, or both as selected.
// - Wake frame sets the sticky wake-seen status bit.
// - Clearing wake enable resumes normal reception.
// - Four filters; wake when enabled filter passes address and CRC.
// - Per-filter offset names first checked byte, set past twelve.
// - 31-bit byte mask selects bytes offset plus j for CRC.
// - In D1 wake detection is always on and cannot be disabled.
// - Broadcast wake frame wakes despite broadcast block.
// - Command bit 0 enables filter; bit 3 selects multicast or unicast.
// - Filter CRC-16 over masked bytes compared with stored value.
//
// Added by the designer: the placing of the registers and register access over APB.
module rxaf_top
  import rxaf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  input wire logic pwr_state_d1,
  output logic fwd_valid,
  output logic fwd_sof,
  output logic fwd_eof,
  output logic [7:0] fwd_data,
  output logic fwd_accept,
  output logic irq_out,
  output logic power_event_out
);

  // ----------------------------------------------------------------
  // Byte lane merge for APB writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] rxaf_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTL_WIDTH-1:0] ctl_q;
  logic [15:0] sta_hi_q;
  logic [31:0] sta_lo_q;
  logic [31:0] hash_hi_q;
  logic [31:0] hash_lo_q;
  logic [31:0] tbl_q [TABLE_WORDS];
  logic [2:0] tbl_ptr_q;
  logic wake_en_q;
  logic wake_seen_q;
  logic irq_sel_q;
  logic pme_sel_q;
  logic last_accept_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire sel_ctl = (paddr == OFS_MAC_CONTROL);
  wire sel_sta_hi = (paddr == OFS_STATION_HI);
  wire sel_sta_lo = (paddr == OFS_STATION_LO);
  wire sel_hash_hi = (paddr == OFS_HASH_HI);
  wire sel_hash_lo = (paddr == OFS_HASH_LO);
  wire sel_tbl = (paddr == OFS_WAKE_TABLE);
  wire sel_wcs = (paddr == OFS_WAKE_CS);
  wire sel_sts = (paddr == OFS_RX_STATUS);
  wire addr_hit = sel_ctl | sel_sta_hi | sel_sta_lo | sel_hash_hi | sel_hash_lo | sel_tbl | sel_wcs | sel_sts;
  wire wr_en = access_ph & pwrite & addr_hit;
  wire wr_tbl = wr_en & sel_tbl;
  wire wr_wcs = wr_en & sel_wcs;
  wire seen_clr = wr_wcs & pstrb[0] & pwdata[WCS_SEEN];

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_hit;
  assign prdata = prdata_q;

  // Read data is sampled in the setup phase so prdata comes from a flop
  wire wake_active;
  wire [31:0] wcs_view = {21'h0, tbl_ptr_q, 4'h0, pme_sel_q, irq_sel_q, wake_en_q, wake_seen_q};
  wire [31:0] sts_view = {30'h0, last_accept_q, wake_active};
  wire [31:0] rd_mux = sel_ctl ? {26'h0, ctl_q} :
                       sel_sta_hi ? {16'h0, sta_hi_q} :
                       sel_sta_lo ? sta_lo_q :
                       sel_hash_hi ? hash_hi_q :
                       sel_hash_lo ? hash_lo_q :
                       sel_tbl ? tbl_q[tbl_ptr_q] :
                       sel_wcs ? wcs_view :
                       sel_sts ? sts_view : RST_ZERO;

  wire [31:0] m_ctl = rxaf_merge({26'h0, ctl_q}, pwdata, pstrb);
  wire [31:0] m_sta_hi = rxaf_merge({16'h0, sta_hi_q}, pwdata, pstrb);
  wire [31:0] m_wcs = rxaf_merge(wcs_view, pwdata, pstrb);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctl_q <= '0;
      sta_hi_q <= RST_STATION_HI;
      sta_lo_q <= RST_STATION_LO;
      hash_hi_q <= RST_ZERO;
      hash_lo_q <= RST_ZERO;
      prdata_q <= RST_ZERO;
    end
    else
    begin
      ctl_q <= (wr_en & sel_ctl) ? m_ctl[CTL_WIDTH-1:0] : ctl_q;
      sta_hi_q <= (wr_en & sel_sta_hi) ? m_sta_hi[15:0] : sta_hi_q;
      sta_lo_q <= (wr_en & sel_sta_lo) ? rxaf_merge(sta_lo_q, pwdata, pstrb) : sta_lo_q;
      hash_hi_q <= (wr_en & sel_hash_hi) ? rxaf_merge(hash_hi_q, pwdata, pstrb) : hash_hi_q;
      hash_lo_q <= (wr_en & sel_hash_lo) ? rxaf_merge(hash_lo_q, pwdata, pstrb) : hash_lo_q;
      prdata_q <= (setup_ph & ~pwrite) ? rd_mux : prdata_q;
    end
  end

  // Table loads through one location; pointer steps per write and wraps
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tbl_ptr_q <= 3'h0;
      for (int w = 0; w < TABLE_WORDS; w++)
      begin
        tbl_q[w] <= RST_ZERO;
      end
    end
    else if (wr_tbl)
    begin
      tbl_q[tbl_ptr_q] <= rxaf_merge(tbl_q[tbl_ptr_q], pwdata, pstrb);
      tbl_ptr_q <= tbl_ptr_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Filter control decode
  // ----------------------------------------------------------------
  wire accept_all = ctl_q[CTL_ACCEPT_ALL];
  wire mcast_pass = ctl_q[CTL_MCAST_PASS];
  wire inverse_sel = ctl_q[CTL_INVERSE];
  wire hash_only = ctl_q[CTL_HASH_ONLY];
  wire hash_perf = ctl_q[CTL_HASH_PERF];
  wire broadcast_block_block = ctl_q[CTL_BROADCAST_BLOCK_BLOCK];
  wire [47:0] station = {sta_hi_q, sta_lo_q};

  // D1 forces detection on; the enable bit cannot turn it off there
  assign wake_active = wake_en_q | pwr_state_d1;

  // ----------------------------------------------------------------
  // Receive byte tracking
  // ----------------------------------------------------------------
  logic [POS_W-1:0] pos_q;
  logic [39:0] da_q;
  logic [31:0] crc_q;
  logic verdict_q;
  logic addr_ok_q;
  logic mcast_q;

  wire take = rx_valid;
  wire [POS_W-1:0] cur_pos = rx_sof ? '0 : pos_q;
  wire [POS_W-1:0] pos_max = '1;
  wire da_done = take & (cur_pos == POS_W'(DA_LAST));
  wire past_da = cur_pos > POS_W'(DA_LAST);
  wire [47:0] da_full = {rx_data, da_q};
  wire [31:0] crc_base = rx_sof ? CRC32_INIT : crc_q;
  wire [31:0] crc_nx = rxaf_crc32(crc_base, rx_data);

  // ----------------------------------------------------------------
  // Address filter decision, valid while da_done
  // ----------------------------------------------------------------
  wire is_mcast = da_full[0];
  wire is_broadcast_block = &da_full;
  wire perfect_hit = (da_full == station);
  wire [5:0] hash_idx = crc_nx[31:26];
  wire hash_hit = hash_idx[5] ? hash_hi_q[hash_idx[4:0]] : hash_lo_q[hash_idx[4:0]];
  wire promisc = accept_all & ~inverse_sel;

  // Priority follows the mode table; unlisted combinations fall to perfect
  wire pass_raw = promisc ? 1'b1 :
                  inverse_sel ? ~perfect_hit :
                  (is_mcast & mcast_pass) ? 1'b1 :
                  (hash_only & hash_perf) ? hash_hit :
                  (hash_perf & is_mcast) ? hash_hit :
                  perfect_hit;
  // Broadcast block never overrides promiscuous acceptance
  wire pass_now = pass_raw & ~(is_broadcast_block & broadcast_block_block & ~promisc);

  // ----------------------------------------------------------------
  // Per-frame tracking registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pos_q <= '0;
      da_q <= '0;
      crc_q <= CRC32_INIT;
      verdict_q <= 1'b0;
      addr_ok_q <= 1'b0;
      mcast_q <= 1'b0;
    end
    else if (take)
    begin
      pos_q <= rx_eof ? '0 : ((cur_pos == pos_max) ? pos_max : cur_pos + POS_W'(1));
      da_q <= {rx_data, da_q[39:8]};
      crc_q <= crc_nx;
      verdict_q <= da_done ? pass_now : (rx_sof ? 1'b0 : verdict_q);
      // Wake address check ignores broadcast block
      addr_ok_q <= da_done ? pass_raw : (rx_sof ? 1'b0 : addr_ok_q);
      mcast_q <= da_done ? is_mcast : mcast_q;
    end
  end

  // ----------------------------------------------------------------
  // Forward path toward the host receive side
  // ----------------------------------------------------------------
  // The six bytes up to and including the decision byte go out; downstream drops on fwd_accept low
  wire frame_ok = da_done ? pass_now : (past_da & verdict_q);
  wire fwd_keep = take & ~wake_active & (~past_da | verdict_q);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fwd_valid <= 1'b0;
      fwd_sof <= 1'b0;
      fwd_eof <= 1'b0;
      fwd_data <= 8'h00;
      fwd_accept <= 1'b0;
      last_accept_q <= 1'b0;
    end
    else
    begin
      fwd_valid <= fwd_keep;
      fwd_sof <= fwd_keep & rx_sof;
      fwd_eof <= take & rx_eof & ~wake_active;
      fwd_data <= take ? rx_data : fwd_data;
      fwd_accept <= take & rx_eof & ~wake_active & frame_ok;
      last_accept_q <= (take & rx_eof) ? frame_ok : last_accept_q;
    end
  end

  // ----------------------------------------------------------------
  // Wake pattern filters
  // ----------------------------------------------------------------
  logic [15:0] wcrc_q [FILT_COUNT];
  logic [15:0] wcrc_d [FILT_COUNT];
  logic [FILT_COUNT-1:0] filt_hit;

  // Each filter folds only its masked bytes into its own CRC-16
  always_comb
  begin
    for (int i = 0; i < FILT_COUNT; i++)
    begin
      logic [7:0] offs;
      logic [POS_W-1:0] rel;
      logic in_win;
      offs = tbl_q[5][8*i +: 8];
      rel = cur_pos - POS_W'(offs);
      in_win = (cur_pos >= POS_W'(offs)) && (rel < POS_W'(MASK_BITS));
      wcrc_d[i] = rx_sof ? CRC16_INIT : wcrc_q[i];
      if (in_win && tbl_q[i][rel[4:0]])
      begin
        wcrc_d[i] = rxaf_crc16(wcrc_d[i], rx_data);
      end
      filt_hit[i] = tbl_q[4][8*i + CMD_ENABLE]
                    & (tbl_q[4][8*i + CMD_MCAST] == mcast_q)
                    & (wcrc_d[i] == tbl_q[6 + i/2][16*(i%2) +: 16])
                    & addr_ok_q & past_da;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < FILT_COUNT; i++)
      begin
        wcrc_q[i] <= CRC16_INIT;
      end
    end
    else if (take)
    begin
      wcrc_q <= wcrc_d;
    end
  end

  // Decision taken at frame end, after the last masked byte
  wire wake_hit = wake_active & take & rx_eof & (|filt_hit);

  // ----------------------------------------------------------------
  // Wake control and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wake_en_q <= 1'b0;
      irq_sel_q <= 1'b0;
      pme_sel_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end
    else
    begin
      wake_en_q <= wr_wcs ? m_wcs[WCS_ENABLE] : wake_en_q;
      irq_sel_q <= wr_wcs ? m_wcs[WCS_IRQ_SEL] : irq_sel_q;
      pme_sel_q <= wr_wcs ? m_wcs[WCS_PME_SEL] : pme_sel_q;
      // Set wins over a write-one-to-clear in the same cycle
      wake_seen_q <= wake_hit | (wake_seen_q & ~seen_clr);
    end
  end

  // Levels follow the sticky bit until software clears it
  assign irq_out = wake_seen_q & irq_sel_q;
  assign power_event_out = wake_seen_q & pme_sel_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_promisc_accept: assert property (da_done && promisc |=> verdict_q)
    else $error("promiscuous frame not accepted");
  a_inverse_reject: assert property (da_done && inverse_sel && perfect_hit |=> !verdict_q)
    else $error("inverse mode accepted own address");
  a_perfect_match: assert property (da_done && ctl_q == '0 && perfect_hit |=> verdict_q)
    else $error("perfect match rejected");
  a_hash_only_sel: assert property (da_done && ctl_q == 6'h18 |=> verdict_q == $past(hash_hit))
    else $error("hash-only decision wrong");
  a_reject_drop: assert property (!wake_active && take && rx_eof && !rx_sof && past_da && !verdict_q
    |=> fwd_eof && !fwd_accept)
    else $error("rejected frame passed");
  a_wake_blocks_rx: assert property (wake_active && $past(wake_active) |-> !fwd_valid && !fwd_accept)
    else $error("data forwarded in wake mode");
  a_seen_set: assert property (wake_hit |=> wake_seen_q ##1 (wake_seen_q || $past(seen_clr)))
    else $error("wake seen not set");
  a_irq_route: assert property (wake_hit && irq_sel_q && !wr_wcs |=> irq_out)
    else $error("interrupt not raised on wake");
  a_d1_forced: assert property (pwr_state_d1 && wr_wcs && !m_wcs[WCS_ENABLE] |=> wake_active)
    else $error("wake detection disabled in D1");
  a_resume_rx: assert property (wr_wcs && !m_wcs[WCS_ENABLE] && !pwr_state_d1 ##1 !pwr_state_d1 |-> !wake_active)
    else $error("normal reception not resumed");
  a_table_ptr: assert property (wr_tbl |=> tbl_ptr_q == $past(tbl_ptr_q) + 3'h1)
    else $error("table pointer did not step");

  c_promisc_frame: cover property (da_done && promisc ##[1:64] fwd_accept);
  c_hash_accept: cover property (da_done && hash_perf && is_mcast && hash_hit);
  c_wake_frame: cover property (wake_hit ##1 power_event_out);
  c_unmapped: cover property (pslverr);

endmodule
